// ==== core/dbgp_probe.sv ====
// debug probe connector logic: scan master, execution sampling, system pins
// assumes clk is the only domain; bus clock, clock return and pins are
// sampled as plain inputs through two flip-flops
//
// What this block does
// - sample six breakpoint lines and target reset on bus clock rising edges
// - drive break-at-reset output onto breakpoint line 5 while break-at-reset is requested and power sense is high, whatever target reset does
// - break-at-reset output changes with no alignment to bus clock
// - test clock half period is a whole number of core cycles, so at most 12.5 MHz, under the 16 MHz limit
// - power sense low tristates all probe outputs except the alternate test clock, which has no enable; high allows control
// - power sense qualifies stable target power and breakpoint sampling
// - synchronous mode launches test clock edges on bus clock rising edges
// - port-active asserted while using the test access interface
// - reset request held low for set duration or forever
// - alternate test clock output copies the test clock
// - returning scan data registered on the clock return input
// - data and mode change when a scan request starts, while test clock is low
// - scan data captured on rising edge of clock return
// - test reset may change at any time
// - target reset is observed only, never resets the probe
`timescale 1ns/10ps
module dbgp_probe
  import dbgp_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // user scan request
  input  wire logic                        scanStart,
  input  wire logic                        scanTms,
  input  wire logic                        scanTdi,
  input  wire logic [dbgp_pkg::DIV_W-1:0]  scanHalfDiv,
  input  wire logic                        scanSyncMode,
  output logic                             scanBusy,
  output logic                             scanDone,
  output logic                             scanTdo,
  // user control
  input  wire logic                        testResetReq,
  input  wire logic                        breakAtResetReq,
  input  wire logic                        resetReqStart,
  input  wire logic                        resetReqForever,
  input  wire logic                        resetReqStop,
  input  wire logic [dbgp_pkg::RST_CNT_W-1:0] resetReqLen,
  // user status
  output logic [dbgp_pkg::BP_W-1:0]        breakpointSample,
  output logic                             targetResetSample,
  output logic                             targetPowered,
  // target inputs
  input  wire logic                        busClock,
  input  wire logic [dbgp_pkg::BP_W-1:0]   breakpoint_lines_n,
  input  wire logic                        targetReset_n,
  input  wire logic                        target_power_sense,
  input  wire logic                        test_clock_return_in,
  input  wire logic                        testDataIn,
  // scan outputs
  output logic                             testClock,
  output logic                             testClockOe,
  output logic                             alt_test_clock_out,
  output logic                             testMode,
  output logic                             testModeOe,
  output logic                             testDataOut,
  output logic                             testDataOutOe,
  output logic                             testReset_n,
  output logic                             testResetOe,
  // system outputs
  output logic                             break_at_reset_drive_n,
  output logic                             breakAtResetOe,
  output logic                             port_active_out_n,
  output logic                             portActiveOe,
  output logic                             reset_request_out_n,
  output logic                             resetRequestOe
);
  import dbgp_pkg::*;

  function automatic logic rise(input logic [1:0] p);
    rise = (p == 2'b01);
  endfunction

  // two-flop synchronisers; second stage plus history for edges
  logic [1:0]       bclkSync_ff, fbSync_ff, pwrSync_ff, rstSync_ff;
  logic [1:0]       tdoSync_ff;
  logic [BP_W-1:0]  bpSync0_ff, bpSync1_ff;
  logic             bclkPrev_ff, fbPrev_ff;
  always_ff @(posedge clk)
  begin
    bclkSync_ff <= {bclkSync_ff[0], busClock};
    fbSync_ff   <= {fbSync_ff[0], test_clock_return_in};
    pwrSync_ff  <= {pwrSync_ff[0], target_power_sense};
    rstSync_ff  <= {rstSync_ff[0], targetReset_n};
    tdoSync_ff  <= {tdoSync_ff[0], testDataIn};
    bpSync0_ff  <= breakpoint_lines_n;
    bpSync1_ff  <= bpSync0_ff;
    bclkPrev_ff <= bclkSync_ff[1];
    fbPrev_ff   <= fbSync_ff[1];
  end

  wire bclkRise = rise({bclkPrev_ff, bclkSync_ff[1]});
  wire fbRise   = rise({fbPrev_ff, fbSync_ff[1]});
  wire powered  = pwrSync_ff[1];

  // execution signals, sampled only while target power is stable
  logic [BP_W-1:0] breakpointSample_ff;
  logic            targetResetSample_ff, targetPowered_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      breakpointSample_ff  <= '0;
      targetResetSample_ff <= 1'b0;
      targetPowered_ff     <= 1'b0;
    end
    else
    begin
      targetPowered_ff <= powered;
      if (bclkRise && powered)
      begin
        breakpointSample_ff  <= ~bpSync1_ff;
        targetResetSample_ff <= ~rstSync_ff[1];
      end
    end
  end
  assign breakpointSample  = breakpointSample_ff;
  assign targetResetSample = targetResetSample_ff;
  assign targetPowered     = targetPowered_ff;

  // scan engine: one bit per request
  dbgp_scan_t      scanSt_ff, nxt_scanSt;
  logic [DIV_W-1:0] divCnt_ff, nxt_divCnt;
  logic [DIV_W-1:0] halfLen_ff;
  logic            syncMode_ff, tckOut_ff, tmsOut_ff, tdiOut_ff;
  logic            tdoCap_ff, scanDone_ff, capSeen_ff, busy_ff;

  wire [DIV_W-1:0] halfReq = (scanHalfDiv < DIV_W'(TCK_HALF_MIN)) ?
                             DIV_W'(TCK_HALF_MIN) : scanHalfDiv;
  wire divHit   = (divCnt_ff == '0);
  // in synchronous mode each test clock edge waits for a rising bus clock edge
  wire edgeOk   = divHit && (!syncMode_ff || bclkRise);
  wire startOk  = scanStart && powered;
  // returned rise may land while the clock is still high, so capture
  // in either half and remember it; one capture per bit
  wire capNow   = fbRise && !capSeen_ff &&
                  (scanSt_ff == SC_HIGH || scanSt_ff == SC_DONE);

  always_comb
  begin
    nxt_scanSt = scanSt_ff;
    nxt_divCnt = divHit ? '0 : divCnt_ff - 1'b1;
    case (scanSt_ff)
      SC_IDLE:
        if (startOk)
        begin
          nxt_scanSt = SC_LOW;
          nxt_divCnt = halfReq - 1'b1;
        end
      SC_LOW:
        if (!powered)
          nxt_scanSt = SC_IDLE;
        else if (edgeOk)
        begin
          nxt_scanSt = SC_HIGH;
          nxt_divCnt = halfLen_ff - 1'b1;
        end
      SC_HIGH:
        if (!powered)
          nxt_scanSt = SC_IDLE;
        else if (edgeOk)
          nxt_scanSt = SC_DONE;
      SC_DONE:
        // leave once the returned clock edge has been captured
        if (capSeen_ff || capNow || !powered)
          nxt_scanSt = SC_IDLE;
      default:
        nxt_scanSt = SC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scanSt_ff   <= SC_IDLE;
      divCnt_ff   <= '0;
      halfLen_ff  <= DIV_DEFAULT;
      syncMode_ff <= 1'b0;
      tckOut_ff   <= 1'b0;
      tmsOut_ff   <= 1'b1;
      tdiOut_ff   <= 1'b1;
      tdoCap_ff   <= 1'b0;
      scanDone_ff <= 1'b0;
      capSeen_ff  <= 1'b0;
      busy_ff     <= 1'b0;
    end
    else
    begin
      scanSt_ff   <= nxt_scanSt;
      divCnt_ff   <= nxt_divCnt;
      scanDone_ff <= 1'b0;
      // busy from the next state so it lines up with scanSt_ff
      busy_ff     <= (nxt_scanSt != SC_IDLE);
      if (scanSt_ff == SC_IDLE && startOk)
      begin
        halfLen_ff  <= halfReq;
        syncMode_ff <= scanSyncMode;
        tmsOut_ff   <= scanTms;
        tdiOut_ff   <= scanTdi;
        capSeen_ff  <= 1'b0;
      end
      if (scanSt_ff == SC_LOW && nxt_scanSt == SC_HIGH)
        tckOut_ff <= 1'b1;
      if (scanSt_ff == SC_HIGH && nxt_scanSt != SC_HIGH)
        tckOut_ff <= 1'b0;
      if (capNow)
      begin
        tdoCap_ff   <= tdoSync_ff[1];
        scanDone_ff <= 1'b1;
        capSeen_ff  <= 1'b1;
      end
    end
  end
  assign testClock          = tckOut_ff;
  assign alt_test_clock_out = tckOut_ff;
  assign testMode           = tmsOut_ff;
  assign testDataOut        = tdiOut_ff;
  assign scanTdo            = tdoCap_ff;
  assign scanDone           = scanDone_ff;
  assign scanBusy           = busy_ff;

  // reset request: timed or held
  logic [RST_CNT_W-1:0] rstCnt_ff;
  logic                 rstHold_ff, rstForever_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rstCnt_ff     <= '0;
      rstHold_ff    <= 1'b0;
      rstForever_ff <= 1'b0;
    end
    // stop and power loss win over a start in the same cycle
    else if (resetReqStop || !powered)
    begin
      rstHold_ff    <= 1'b0;
      rstForever_ff <= 1'b0;
      rstCnt_ff     <= '0;
    end
    else if (resetReqStart)
    begin
      rstHold_ff    <= 1'b1;
      rstForever_ff <= resetReqForever;
      rstCnt_ff     <= resetReqLen;
    end
    else if (rstHold_ff && !rstForever_ff)
    begin
      if (rstCnt_ff == '0)
        rstHold_ff <= 1'b0;
      else
        rstCnt_ff <= rstCnt_ff - 1'b1;
    end
  end

  // pin drivers; every output enable drops when power sense is low
  logic trstOut_ff, trstOe_ff, brkOe_ff, dbaOe_ff, dbrOe_ff, oe_ff;
  // port-active pin level kept in its own flop, low while active
  logic portActive_n_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      oe_ff      <= 1'b0;
      trstOut_ff <= 1'b0;
      trstOe_ff  <= 1'b0;
      brkOe_ff   <= 1'b0;
      dbaOe_ff   <= 1'b0;
      dbrOe_ff   <= 1'b0;
      portActive_n_ff <= 1'b1;
    end
    else
    begin
      oe_ff      <= powered;
      trstOut_ff <= ~testResetReq;
      trstOe_ff  <= powered;
      brkOe_ff   <= powered && breakAtResetReq;
      portActive_n_ff <= !(powered && (scanBusy || testResetReq));
      dbaOe_ff   <= powered && (scanBusy || testResetReq);
      dbrOe_ff   <= powered && rstHold_ff;
    end
  end
  assign testClockOe            = oe_ff;
  assign testModeOe             = oe_ff;
  assign testDataOutOe          = oe_ff;
  assign testReset_n            = trstOut_ff;
  assign testResetOe            = trstOe_ff;
  // open-drain pins: drive low only, enable carries the assertion
  assign break_at_reset_drive_n = 1'b0;
  assign breakAtResetOe         = brkOe_ff;
  assign port_active_out_n      = portActive_n_ff;
  assign portActiveOe           = dbaOe_ff;
  assign reset_request_out_n    = 1'b0;
  assign resetRequestOe         = dbrOe_ff;
endmodule

// ==== include/dbgp_pkg.sv ====
// constants for the debug probe port logic
// assumes a 25 MHz core clock; no bus, user side is plain ports
package dbgp_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned TCK_MAX_HZ    = 16000000;
  // half period of the test clock in core cycles, rounded up (slower side)
  localparam int unsigned TCK_HALF_MIN  =
    (CLK_HZ + 2 * TCK_MAX_HZ - 1) / (2 * TCK_MAX_HZ);
  localparam int unsigned DIV_W         = 8;
  localparam logic [7:0]  DIV_DEFAULT   = 8'h01;
  localparam int unsigned RST_CNT_W     = 16;
  localparam int unsigned BP_W          = 6;
  localparam int unsigned BP_BRK_IDX    = 5;
  localparam logic [1:0]  PAIR_HI       = 2'h3;
  localparam logic [1:0]  PAIR_LO       = 2'h0;

  typedef enum logic [3:0]
  {
    SC_IDLE  = 4'h1,
    SC_LOW   = 4'h2,
    SC_HIGH  = 4'h4,
    SC_DONE  = 4'h8
  } dbgp_scan_t;
endpackage

// ==== tb/dbgp_probe_sva.sv ====
// assertions on the debug probe ports
// bound into every dbgp_probe; single clk domain, srst synchronous
`timescale 1ns/10ps
module dbgp_probe_sva
(
  // clock and reset
  input wire logic clk, srst,
  // scan side
  input wire logic scanBusy, scanDone, testClock, alt_test_clock_out,
  input wire logic testClockOe, testModeOe, testDataOutOe, testDataOut,
  input wire logic test_clock_return_in, testResetOe,
  // system side
  input wire logic target_power_sense, targetPowered, portActiveOe,
  input wire logic breakAtResetReq, breakAtResetOe, break_at_reset_drive_n,
  input wire logic resetReqStart, resetReqStop, resetRequestOe,
  input wire logic reset_request_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_unpowered_float: assert property (
    !target_power_sense [*4] |-> !(testClockOe | testModeOe | testDataOutOe
      | testResetOe | breakAtResetOe | resetRequestOe | portActiveOe))
    else $error("outputs driven without power");
  a_busy_active: assert property (
    scanBusy [*2] |-> portActiveOe)
    else $error("port active missing during scan");
  a_alt_clock_copy: assert property (
    alt_test_clock_out == testClock)
    else $error("alternate clock differs");
  a_tdi_on_fall: assert property (
    $changed(testDataOut) |-> !testClock)
    else $error("data changed with clock high");
  a_done_after_return: assert property (
    $rose(test_clock_return_in) && scanBusy |-> ##[2:8] scanDone)
    else $error("no capture after clock return");
  a_rreq_start: assert property (
    resetReqStart && !resetReqStop && targetPowered && !resetRequestOe
      |-> ##2 resetRequestOe && !reset_request_out_n)
    else $error("reset request not raised");
  a_rreq_stop: assert property (
    resetReqStop |-> ##2 !resetRequestOe)
    else $error("reset request not dropped");
  a_break_drive: assert property (
    (breakAtResetReq && targetPowered) [*2]
      |-> breakAtResetOe && !break_at_reset_drive_n)
    else $error("break-at-reset not driven");

  c_scan: cover property (scanDone);
  c_rreq: cover property ($rose(resetRequestOe));
  c_float: cover property ($fell(portActiveOe));
endmodule

bind dbgp_probe dbgp_probe_sva u_sva (.*);

// ==== tb/dbgp_probe_tb.sv ====
// self-checking bench for the debug probe port logic
// drives user side, target pins and power sense; target model on the chain
`timescale 1ns/10ps
module dbgp_probe_tb;
  import dbgp_pkg::*;
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
  end end
  logic clk = 1'h0, srst = 1'h1;
  logic scanStart = 1'h0, scanTms = 1'h0, scanTdi = 1'h0;
  logic scanSyncMode = 1'h0, testResetReq = 1'h0, breakAtResetReq = 1'h0;
  logic resetReqStart = 1'h0, resetReqForever = 1'h0, resetReqStop = 1'h0;
  logic [DIV_W-1:0] scanHalfDiv = 8'h01;
  logic [RST_CNT_W-1:0] resetReqLen = 16'h0014;
  logic [BP_W-1:0] bpTgt = 6'h3F, breakpoint_lines_n, breakpointSample;
  logic targetReset_n = 1'h1, target_power_sense = 1'h1, busClock;
  logic test_clock_return_in, testDataIn, scanBusy, scanDone, scanTdo;
  logic targetResetSample, targetPowered, testClock, testClockOe;
  logic alt_test_clock_out, testMode, testModeOe, testDataOut;
  logic testDataOutOe, testReset_n, testResetOe, break_at_reset_drive_n;
  logic breakAtResetOe, port_active_out_n, portActiveOe;
  logic reset_request_out_n, resetRequestOe;
  int fail_count = 0, num_checks = 0;

  // break-at-reset output is wired onto breakpoint line 5
  assign breakpoint_lines_n = bpTgt & {~breakAtResetOe, 5'h1F};
  always #20 clk = ~clk;
  dbgp_probe u_dut (.*);
  dbgp_target_model u_far (.*);

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic shift(input logic tms, tdi, output logic tdo);
    int n;
    scanTms = tms;
    scanTdi = tdi;
    scanStart = 1'h1;
    step(1);
    scanStart = 1'h0;
    `CHK("mode out", tms, testMode)
    `CHK("data out", tdi, testDataOut)
    for (n = 0; n < 300 && scanDone !== 1'h1; n++) step(1);
    `CHK("scan done", 1'h1, scanDone)
    tdo = scanTdo;
    for (n = 0; n < 20 && scanBusy === 1'h1; n++) step(1);
    step(1);
  endtask

  task automatic t_scan(input logic [7:0] div, input logic sync);
    logic prev, tdo;
    logic [4:0] pat;
    pat = 5'h19;
    scanHalfDiv = div;
    scanSyncMode = sync;
    shift(1'h0, 1'h1, tdo);
    prev = 1'h1;
    for (int i = 0; i < 5; i++)
    begin
      shift(pat[i], pat[i], tdo);
      `CHK("returned bit", prev, tdo)
      prev = pat[i];
    end
    $display("scan test div %0d sync %0d ended", div, sync);
  endtask

  task automatic t_exec;
    logic tdo;
    bpTgt = 6'h2A;
    targetReset_n = 1'h0;
    breakAtResetReq = 1'h1;
    step(30);
    `CHK("breakpoints", 6'h35, breakpointSample)
    `CHK("target reset", 1'h1, targetResetSample)
    `CHK("powered", 1'h1, targetPowered)
    shift(1'h0, 1'h0, tdo);
    `CHK("chain intact", 1'h1, tdo)
    `CHK("probe unaffected", 1'h0, scanBusy)
    targetReset_n = 1'h1;
    bpTgt = 6'h3F;
    $display("execution test ended");
  endtask

  task automatic t_rreq;
    int n;
    resetReqStart = 1'h1;
    step(1);
    resetReqStart = 1'h0;
    for (n = 0; n < 4 && resetRequestOe !== 1'h1; n++) step(1);
    for (n = 0; n < 100 && resetRequestOe === 1'h1; n++) step(1);
    `CHK("hold length", 1'h1, 1'(n >= 21 && n <= 22))
    resetReqForever = 1'h1;
    resetReqStart = 1'h1;
    step(1);
    resetReqStart = 1'h0;
    step(200);
    `CHK("held", 1'h1, resetRequestOe & ~reset_request_out_n)
    resetReqStop = 1'h1;
    step(1);
    resetReqStop = 1'h0;
    resetReqForever = 1'h0;
    step(2);
    `CHK("stopped", 1'h0, resetRequestOe)
    $display("reset request test ended");
  endtask

  task automatic t_power;
    testResetReq = 1'h1;
    step(4);
    `CHK("test reset", 1'h1, testResetOe & ~testReset_n)
    `CHK("port active", 1'h1, portActiveOe)
    `CHK("active pin", 1'h0, port_active_out_n)
    target_power_sense = 1'h0;
    step(4);
    `CHK("released", 1'h0, testClockOe | testResetOe | breakAtResetOe)
    `CHK("inactive", 1'h0, portActiveOe)
    scanStart = 1'h1;
    step(2);
    scanStart = 1'h0;
    `CHK("start refused", 1'h0, scanBusy)
    target_power_sense = 1'h1;
    testResetReq = 1'h0;
    breakAtResetReq = 1'h0;
    step(8);
    $display("power test ended");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    step(16);
    srst = 1'h0;
    step(8);
    t_scan(8'h01, 1'h0);
    t_scan(8'h03, 1'h1);
    t_exec;
    t_rreq;
    t_power;
    wrap_up;
  end

  initial
  begin
    #400us;
    fail_count++;
    wrap_up;
  end
endmodule

// ==== tb/dbgp_target_model.sv ====
// far side: a one-cell bypass scan chain and the target bus clock
// clock return is the test clock after a board delay; pull-down when floated
`timescale 1ns/10ps
module dbgp_target_model
#(
  parameter time RET_DLY = 7ns
)
(
  // from the probe
  input  wire logic testClock,
  input  wire logic testClockOe,
  input  wire logic testDataOut,
  // to the probe
  output logic      test_clock_return_in,
  output logic      testDataIn,
  output logic      busClock
);
  logic bypassBit = 1'h1;
  logic tckLine;

  initial busClock = 1'h0;
  always #160 busClock = ~busClock;
  assign tckLine = testClockOe ? testClock : 1'h0;
  assign #(RET_DLY) test_clock_return_in = tckLine;
  // cell samples on rise, turns its output on fall
  initial testDataIn = 1'h1;
  always @(posedge test_clock_return_in) bypassBit <= testDataOut;
  always @(negedge test_clock_return_in) testDataIn <= bypassBit;
endmodule
